// ==== hdl/bbc_core.sv ====
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - one instruction cycle per cpu clock period
// - short count for fast RAM, long otherwise
// - set test short direct: 3 bytes, 8/9
// - set test sfr bit: 4 bytes, 11
// - set test accumulator bit: 3 bytes, 8
// - set test status word bit: 3 bytes, 9
// - set test pointer byte bit: 3 bytes, 10/11
// - clear test short direct: 4 bytes, 10/11
// - clear test sfr or status: 4 bytes, 11
// - clear test accumulator 8, pointer 10/11
// - set-then-clear short direct: 4 bytes, 10/12
// - set-then-clear sfr bit: 4 bytes, 12
// - set-then-clear accumulator bit: 3 bytes, 8
// - set-then-clear status word bit: 4 bytes, 12
// - set-then-clear pointer byte: 3 bytes, 10/12
// - decrement B or C, branch if nonzero
// - decrement short direct byte, branch if nonzero
// - enable instruction sets interrupt enable flag
// - mask instruction clears interrupt enable flag
module bbc_core (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [bbc_pkg::BBC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [bbc_pkg::BBC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic busy,
    output logic halt_mode,
    output logic stop_mode,
    output logic global_irq_enable_flag,
    output logic [1:0] bank_select_bits
);
    import bbc_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_HALT, ST_STOP} bbc_state_t;

    bbc_state_t state_q;
    bbc_insn_t insn_q;
    logic [15:0] pc_q;
    logic [7:0] opnd_q;
    logic [7:0] reg_b_q, reg_c_q, acc_q;
    logic [7:0] psw_q;
    logic [2:0] clksel_q;
    logic [7:0] div_q;
    logic [3:0] cyc_q;
    logic taken_q;
    logic [3:0] last_cyc_q;

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    logic [BBC_ADDR_W-1:0] awaddr_q, araddr_w;
    logic aw_full_q, w_full_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire;
    logic wr_hit;
    logic idle;

    assign s_axi_awready = !aw_full_q;
    assign s_axi_wready = !w_full_q;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid;
    assign idle = (state_q == ST_IDLE);
    assign araddr_w = s_axi_araddr;

    // byte-lane merge of write data into a register
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // address and data holding, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (s_axi_awvalid && !aw_full_q) begin
                aw_full_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_full_q <= 1'b0;
            end
            if (s_axi_wvalid && !w_full_q) begin
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_full_q <= 1'b0;
            end
        end
    end

    // write address decode
    always_comb begin
        case (awaddr_q)
            BBC_OFS_CTRL, BBC_OFS_INSN, BBC_OFS_PC, BBC_OFS_OPND,
            BBC_OFS_REGS, BBC_OFS_PSW, BBC_OFS_CLKSEL: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= BBC_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? BBC_RESP_OKAY : BBC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // strobes into the register file; config writes are dropped unless the core is idle
    logic wr_ctrl, wr_cfg;
    logic [31:0] wmerged;
    assign wr_ctrl = wr_fire && (awaddr_q == BBC_OFS_CTRL) && wstrb_q[0];
    assign wr_cfg = wr_fire && idle;

    // ------------------------------------------------------------
    // instruction timing table
    // ------------------------------------------------------------
    function automatic bbc_timing_t timing(input bbc_insn_t i);
        bbc_timing_t t;
        logic far;
        far = i.outside_hsram;
        t = '{len: 3'd2, cyc: 4'd6};
        case (i.op)
            OP_BT: begin
                case (i.space)
                    SP_SFR: t = '{len: 3'd4, cyc: 4'd11};
                    SP_ACC: t = '{len: 3'd3, cyc: 4'd8};
                    SP_PSW: t = '{len: 3'd3, cyc: 4'd9};
                    SP_HL: t = '{len: 3'd3, cyc: far ? 4'd11 : 4'd10};
                    default: t = '{len: 3'd3, cyc: far ? 4'd9 : 4'd8};
                endcase
            end
            OP_BF: begin
                case (i.space)
                    SP_SFR, SP_PSW: t = '{len: 3'd4, cyc: 4'd11};
                    SP_ACC: t = '{len: 3'd3, cyc: 4'd8};
                    SP_HL: t = '{len: 3'd3, cyc: far ? 4'd11 : 4'd10};
                    default: t = '{len: 3'd4, cyc: far ? 4'd11 : 4'd10};
                endcase
            end
            OP_BRANCH_IF_SET_THEN_CLEAR: begin
                case (i.space)
                    SP_SFR: t = '{len: 3'd4, cyc: 4'd12};
                    SP_ACC: t = '{len: 3'd3, cyc: 4'd8};
                    SP_PSW: t = '{len: 3'd4, cyc: 4'd12};
                    SP_HL: t = '{len: 3'd3, cyc: far ? 4'd12 : 4'd10};
                    default: t = '{len: 3'd4, cyc: far ? 4'd12 : 4'd10};
                endcase
            end
            OP_DECREMENT_BRANCH_NONZERO: begin
                case (i.space)
                    SP_REGB, SP_REGC: t = '{len: 3'd2, cyc: 4'd6};
                    default: t = '{len: 3'd3, cyc: far ? 4'd10 : 4'd8};
                endcase
            end
            OP_SEL: t = '{len: 3'd2, cyc: 4'd4};
            OP_NOP: t = '{len: 3'd1, cyc: 4'd2};
            default: t = '{len: 3'd2, cyc: 4'd6};
        endcase
        return t;
    endfunction : timing

    // ------------------------------------------------------------
    // execution datapath
    // ------------------------------------------------------------
    bbc_timing_t tim;
    logic [7:0] src;
    logic [7:0] dec;
    logic bit_val;
    logic take;
    logic [15:0] target;
    logic [15:0] next_pc;
    logic [7:0] cleared;

    assign tim = timing(insn_q);

    // operand byte selected by addressing space
    always_comb begin
        case (insn_q.space)
            SP_ACC: src = acc_q;
            SP_PSW: src = psw_q;
            SP_REGB: src = reg_b_q;
            SP_REGC: src = reg_c_q;
            default: src = opnd_q;
        endcase
    end

    assign bit_val = src[insn_q.bitsel];
    assign dec = src - 8'h01;
    assign cleared = src & ~(8'h01 << insn_q.bitsel);

    // branch decision per instruction
    always_comb begin
        case (insn_q.op)
            OP_BT, OP_BRANCH_IF_SET_THEN_CLEAR: take = bit_val;
            OP_BF: take = !bit_val;
            OP_DECREMENT_BRANCH_NONZERO: take = (dec != 8'h00);
            default: take = 1'b0;
        endcase
    end

    // pc plus length, plus sign-extended offset when taken
    assign next_pc = pc_q + {13'h0000, tim.len};
    assign target = next_pc + {{8{insn_q.offset[7]}}, insn_q.offset};

    // ------------------------------------------------------------
    // instruction cycle pacing
    // ------------------------------------------------------------
    logic tick;
    logic [7:0] div_max;
    logic commit;

    // cpu clock is aclk divided by 2**clksel
    assign div_max = 8'((9'h001 << clksel_q) - 9'h001);
    assign tick = (div_q == div_max);
    assign commit = (state_q == ST_EXEC) && tick && (cyc_q == tim.cyc - 4'd1);

    // divider runs only during execution
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= '0;
        end else if (state_q != ST_EXEC || tick) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // elapsed instruction cycles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cyc_q <= '0;
        end else if (state_q != ST_EXEC) begin
            cyc_q <= '0;
        end else if (tick) begin
            cyc_q <= cyc_q + 4'd1;
        end
    end

    // ------------------------------------------------------------
    // control state
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (wr_ctrl && wdata_q[BBC_CTRL_START]) begin
                        state_q <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    if (commit) begin
                        if (insn_q.op == OP_HALT) begin
                            state_q <= ST_HALT;
                        end else if (insn_q.op == OP_STOP) begin
                            state_q <= ST_STOP;
                        end else begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_HALT, ST_STOP: begin
                    if (wr_ctrl && wdata_q[BBC_CTRL_RELEASE]) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // software-loaded instruction and clock select
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            insn_q <= '0;
            clksel_q <= BBC_CLKSEL_RST;
        end else if (wr_cfg) begin
            if (awaddr_q == BBC_OFS_INSN) begin
                insn_q <= bbc_insn_t'(24'(merge({8'h00, insn_q}, wdata_q, wstrb_q) & 32'h00FF07FF));
            end
            if (awaddr_q == BBC_OFS_CLKSEL && wstrb_q[0]) begin
                clksel_q <= wdata_q[2:0];
            end
        end
    end

    // program counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_q <= BBC_PC_RST;
        end else if (commit) begin
            pc_q <= take ? target : next_pc;
        end else if (wr_cfg && awaddr_q == BBC_OFS_PC) begin
            pc_q <= 16'(merge({16'h0000, pc_q}, wdata_q, wstrb_q));
        end
    end

    // memory operand byte and general registers
    assign wmerged = merge({8'h00, acc_q, reg_c_q, reg_b_q}, wdata_q, wstrb_q);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            opnd_q <= '0;
            reg_b_q <= '0;
            reg_c_q <= '0;
            acc_q <= '0;
        end else if (commit) begin
            case (insn_q.op)
                OP_BRANCH_IF_SET_THEN_CLEAR: begin
                    if (bit_val) begin
                        case (insn_q.space)
                            SP_ACC: acc_q <= cleared;
                            SP_SADDR, SP_SFR, SP_HL: opnd_q <= cleared;
                            default: ;
                        endcase
                    end
                end
                OP_DECREMENT_BRANCH_NONZERO: begin
                    case (insn_q.space)
                        SP_REGB: reg_b_q <= dec;
                        SP_REGC: reg_c_q <= dec;
                        default: opnd_q <= dec;
                    endcase
                end
                default: ;
            endcase
        end else if (wr_cfg) begin
            if (awaddr_q == BBC_OFS_OPND && wstrb_q[0]) begin
                opnd_q <= wdata_q[7:0];
            end
            if (awaddr_q == BBC_OFS_REGS) begin
                reg_b_q <= wmerged[7:0];
                reg_c_q <= wmerged[15:8];
                acc_q <= wmerged[23:16];
            end
        end
    end

    // program status word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            psw_q <= BBC_PSW_RST;
        end else if (commit) begin
            case (insn_q.op)
                OP_EI: psw_q[BBC_PSW_IE] <= 1'b1;
                OP_DI: psw_q[BBC_PSW_IE] <= 1'b0;
                OP_SEL: begin
                    psw_q[BBC_PSW_RBS1] <= insn_q.bitsel[1];
                    psw_q[BBC_PSW_RBS0] <= insn_q.bitsel[0];
                end
                OP_BRANCH_IF_SET_THEN_CLEAR: begin
                    if (bit_val && insn_q.space == SP_PSW) begin
                        psw_q <= cleared;
                    end
                end
                default: ;
            endcase
        end else if (wr_cfg && awaddr_q == BBC_OFS_PSW && wstrb_q[0]) begin
            psw_q <= wdata_q[7:0];
        end
    end

    // outcome of the last executed instruction
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            taken_q <= 1'b0;
            last_cyc_q <= '0;
        end else if (commit) begin
            taken_q <= take;
            last_cyc_q <= tim.cyc;
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    logic [31:0] rd_val;
    logic rd_hit;

    always_comb begin
        rd_hit = 1'b1;
        case (araddr_w)
            BBC_OFS_CTRL: rd_val = 32'h00000000;
            BBC_OFS_INSN: rd_val = {8'h00, insn_q};
            BBC_OFS_PC: rd_val = {16'h0000, pc_q};
            BBC_OFS_OPND: rd_val = {24'h000000, opnd_q};
            BBC_OFS_REGS: rd_val = {8'h00, acc_q, reg_c_q, reg_b_q};
            BBC_OFS_PSW: rd_val = {24'h000000, psw_q};
            BBC_OFS_CLKSEL: rd_val = {29'h00000000, clksel_q};
            BBC_OFS_STATUS: rd_val = {16'h0000, 4'h0, last_cyc_q, 3'h0, taken_q,
                                      stop_mode, halt_mode, 1'b0, busy};
            BBC_OFS_RESULT: rd_val = {tim.cyc, 1'b0, tim.len, 8'h00, target};
            default: begin
                rd_val = 32'h00000000;
                rd_hit = 1'b0;
            end
        endcase
    end

    // registered read answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= BBC_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? BBC_RESP_OKAY : BBC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------
    assign busy = (state_q == ST_EXEC);
    assign halt_mode = (state_q == ST_HALT);
    assign stop_mode = (state_q == ST_STOP);
    assign global_irq_enable_flag = psw_q[BBC_PSW_IE];
    assign bank_select_bits = {psw_q[BBC_PSW_RBS1], psw_q[BBC_PSW_RBS0]};

endmodule : bbc_core
`default_nettype wire

// ==== hdl/bbc_pkg.sv ====
package bbc_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam int BBC_ADDR_W = 8;
    localparam logic [7:0] BBC_OFS_CTRL = 8'h00;
    localparam logic [7:0] BBC_OFS_INSN = 8'h04;
    localparam logic [7:0] BBC_OFS_PC = 8'h08;
    localparam logic [7:0] BBC_OFS_OPND = 8'h0C;
    localparam logic [7:0] BBC_OFS_REGS = 8'h10;
    localparam logic [7:0] BBC_OFS_PSW = 8'h14;
    localparam logic [7:0] BBC_OFS_CLKSEL = 8'h18;
    localparam logic [7:0] BBC_OFS_STATUS = 8'h1C;
    localparam logic [7:0] BBC_OFS_RESULT = 8'h20;

    // control register bits
    localparam int BBC_CTRL_START = 0;
    localparam int BBC_CTRL_RELEASE = 1;

    // program status word bit positions
    localparam int BBC_PSW_CY = 0;
    localparam int BBC_PSW_RBS0 = 3;
    localparam int BBC_PSW_AC = 4;
    localparam int BBC_PSW_RBS1 = 5;
    localparam int BBC_PSW_Z = 6;
    localparam int BBC_PSW_IE = 7;

    // values after reset
    localparam logic [7:0] BBC_PSW_RST = 8'h02;
    localparam logic [15:0] BBC_PC_RST = 16'h0000;
    localparam logic [2:0] BBC_CLKSEL_RST = 3'h0;

    // axi responses
    localparam logic [1:0] BBC_RESP_OKAY = 2'h0;
    localparam logic [1:0] BBC_RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // instruction encoding
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NOP, OP_BT, OP_BF, OP_BRANCH_IF_SET_THEN_CLEAR, OP_DECREMENT_BRANCH_NONZERO,
        OP_SEL, OP_EI, OP_DI, OP_HALT, OP_STOP
    } bbc_op_t;

    typedef enum logic [2:0] {
        SP_SADDR, SP_SFR, SP_ACC, SP_PSW, SP_HL, SP_REGB, SP_REGC
    } bbc_space_t;

    // insn register: op [3:0], space [6:4], bit [9:7], far [10], offset [23:16]
    typedef struct packed {
        logic [7:0] offset;
        logic [4:0] rsvd;
        logic outside_hsram;
        logic [2:0] bitsel;
        bbc_space_t space;
        bbc_op_t op;
    } bbc_insn_t;

    // length in bytes and count of instruction cycles
    typedef struct packed {
        logic [2:0] len;
        logic [3:0] cyc;
    } bbc_timing_t;

endpackage : bbc_pkg

// ==== tb/bbc_core_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// port checks for the bit branch core
// ------------------------------------------------------------
module bbc_core_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_arready,
    input wire logic busy,
    input wire logic halt_mode,
    input wire logic stop_mode,
    input wire logic global_irq_enable_flag,
    input wire logic [1:0] bank_select_bits
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic [11:0] run_q;
    // length of the current busy stretch
    always_ff @(posedge aclk) begin
        if (!aresetn || !busy) run_q <= 12'h000;
        else run_q <= run_q + 12'h001;
    end
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer lost");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer lost");
    chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address open while answer pending");
    chk_busy_min: assert property ($rose(busy) |=> busy)
        else $error("instruction shorter than two cycles");
    chk_busy_max: assert property (run_q <= 12'h600)
        else $error("instruction too long");
    chk_irq_set: assert property ($rose(global_irq_enable_flag) |->
        $fell(busy) || $rose(s_axi_bvalid)) else $error("irq flag set without cause");
    chk_irq_clear: assert property ($past(aresetn) && $fell(global_irq_enable_flag) |->
        $fell(busy) || $rose(s_axi_bvalid)) else $error("irq flag cleared without cause");
    chk_bank_load: assert property ($past(aresetn) && $changed(bank_select_bits) |->
        $fell(busy) || $rose(s_axi_bvalid)) else $error("bank changed without cause");
    chk_mode_entry: assert property ($rose(halt_mode) || $rose(stop_mode) |-> $fell(busy))
        else $error("suspend without instruction end");
    chk_mode_exit: assert property ($past(aresetn) && ($fell(halt_mode) || $fell(stop_mode)) |->
        $rose(s_axi_bvalid)) else $error("suspend left without release");
    chk_mode_excl: assert property ($onehot0({busy, halt_mode, stop_mode}))
        else $error("busy and suspend overlap");
endmodule : bbc_core_asserts

bind bbc_core bbc_core_asserts chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_arready, .busy, .halt_mode, .stop_mode,
    .global_irq_enable_flag, .bank_select_bits);
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// bench for the bit branch core
// ------------------------------------------------------------
module tb_top;
    import bbc_pkg::*;
    logic aclk, aresetn, busy, halt_mode, stop_mode, global_irq_enable_flag;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, bank_select_bits, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int bad_count = 0;
    int cmp_count = 0;
    int run_q = 0;
    int last_q = 0;
    bbc_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .busy, .halt_mode, .stop_mode, .global_irq_enable_flag, .bank_select_bits);
    // length of the last busy stretch
    always @(posedge aclk) begin
        if (busy) run_q <= run_q + 1;
        else if (run_q != 0) begin
            last_q <= run_q;
            run_q <= 0;
        end
    end
    task automatic conclude();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one bus write, response kept in rs
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 99);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    // one bus read, data in rv and response in rs
    task automatic rd(input logic [7:0] a);
        int n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 99);
        rv = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    function automatic logic [31:0] mk(bbc_op_t op, bbc_space_t sp, logic [2:0] b, logic f);
        return {8'h00, 8'hFC, 5'h00, f, b, sp, op};
    endfunction : mk
    // load, start, wait for the end, compare the busy length
    task automatic run(input logic [31:0] insn, input int cyc);
        int n = 0;
        wr(BBC_OFS_INSN, insn);
        wr(BBC_OFS_CTRL, 32'h1);
        while (busy && n < 2000) begin
            @(posedge aclk);
            n++;
        end
        @(posedge aclk);
        chk(last_q, cyc);
    endtask : run
    task automatic t_reset();
        rd(BBC_OFS_PSW);
        chk(rv, 32'h2);
        rd(8'h3C);
        chk({rv, rs}, {32'h0, BBC_RESP_SLVERR});
        wr(8'h40, 32'h1);
        chk(rs, BBC_RESP_SLVERR);
    endtask : t_reset
    // every bit test branch in every space, near and far
    task automatic t_bits();
        int cs[3][5] = '{'{8, 11, 8, 9, 10}, '{10, 11, 8, 11, 10}, '{10, 12, 8, 12, 10}};
        int cl[3][5] = '{'{9, 11, 8, 9, 11}, '{11, 11, 8, 11, 11}, '{12, 12, 8, 12, 12}};
        int ln[3][5] = '{'{3, 4, 3, 3, 3}, '{4, 4, 3, 4, 3}, '{4, 4, 3, 4, 3}};
        int c;
        for (int o = 0; o < 3; o++) begin
            for (int s = 0; s < 10; s++) begin
                c = s < 5 ? cs[o][s % 5] : cl[o][s % 5];
                wr(BBC_OFS_PC, 32'h100);
                wr(BBC_OFS_OPND, 32'h20);
                wr(BBC_OFS_REGS, 32'h0020_0000);
                wr(BBC_OFS_PSW, 32'h22);
                run(mk(bbc_op_t'(o + 1), bbc_space_t'(s % 5), 3'h5, s >= 5), c);
                rd(BBC_OFS_PC);
                chk(rv, 32'h100 + ln[o][s % 5] - (o == 1 ? 0 : 4));
                rd(BBC_OFS_STATUS);
                chk({rv[11:8], rv[4]}, {c[3:0], o != 1});
                if (o == 2) begin
                    rd(s % 5 == 2 ? BBC_OFS_REGS : s % 5 == 3 ? BBC_OFS_PSW : BBC_OFS_OPND);
                    chk(rv & 32'h0020_0020, 32'h0);
                end
            end
        end
    endtask : t_bits
    // decrement loops, taken and falling through to zero
    task automatic t_decrement_branch_nonzero();
        bbc_space_t sp;
        for (int i = 0; i < 8; i++) begin
            sp = i[2:1] == 2'h0 ? SP_REGB : i[2:1] == 2'h1 ? SP_REGC : SP_SADDR;
            wr(BBC_OFS_PC, 32'h100);
            wr(BBC_OFS_REGS, {16'h0, 7'h0, i[0], 7'h0, i[0]});
            wr(BBC_OFS_OPND, {31'h0, i[0]});
            run(mk(OP_DECREMENT_BRANCH_NONZERO, sp, 3'h0, i[1]), sp != SP_SADDR ? 6 : i[1] ? 10 : 8);
            rd(BBC_OFS_PC);
            chk(rv, 32'h100 + (sp == SP_SADDR ? 3 : 2) - (i[0] ? 0 : 4));
            rd(sp == SP_SADDR ? BBC_OFS_OPND : BBC_OFS_REGS);
            chk(sp == SP_REGC ? rv[15:8] : rv[7:0], i[0] ? 8'h00 : 8'hFF);
        end
    endtask : t_decrement_branch_nonzero
    // control group, suspend and release
    task automatic t_ctrl();
        logic [31:0] p;
        wr(BBC_OFS_PC, 32'h100);
        run(mk(OP_NOP, SP_SADDR, 3'h0, 1'b0), 2);
        rd(BBC_OFS_PC);
        chk(rv, 32'h101);
        for (int n = 1; n < 5; n++) begin
            run(mk(OP_SEL, SP_SADDR, {1'b0, n[1:0]}, 1'b0), 4);
            chk(bank_select_bits, n[1:0]);
        end
        run(mk(OP_EI, SP_SADDR, 3'h0, 1'b0), 6);
        chk(global_irq_enable_flag, 1'b1);
        run(mk(OP_DI, SP_SADDR, 3'h0, 1'b0), 6);
        chk(global_irq_enable_flag, 1'b0);
        for (int m = 0; m < 2; m++) begin
            run(mk(m ? OP_STOP : OP_HALT, SP_SADDR, 3'h0, 1'b0), 6);
            rd(BBC_OFS_PC);
            p = rv;
            wr(BBC_OFS_CTRL, 32'h1);
            wr(BBC_OFS_PC, 32'h0);
            rd(BBC_OFS_PC);
            chk(rv, p);
            chk({busy, halt_mode, stop_mode}, m ? 3'h1 : 3'h2);
            wr(BBC_OFS_CTRL, 32'h2);
            @(posedge aclk);
            chk({halt_mode, stop_mode}, 2'h0);
        end
    endtask : t_ctrl
    // slower cpu clock stretches every cycle
    task automatic t_clk();
        wr(BBC_OFS_CLKSEL, 32'h3);
        run(mk(OP_NOP, SP_SADDR, 3'h0, 1'b0), 16);
        wr(BBC_OFS_CLKSEL, 32'h7);
        run(mk(OP_BRANCH_IF_SET_THEN_CLEAR, SP_SFR, 3'h0, 1'b1), 1536);
        wr(BBC_OFS_CLKSEL, 32'h0);
    endtask : t_clk
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    initial begin
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_bits();
        t_decrement_branch_nonzero();
        t_ctrl();
        t_clk();
        conclude();
    end
    // hang guard, well past the expected run length
    initial begin
        #100000;
        bad_count++;
        conclude();
    end
endmodule : tb_top
`default_nettype wire
